/* rtl/sdram_engine.sv */
// Synchronous DRAM command generation and normal read/write engine
`include "sdram_engine_consts.svh"

module sdram_engine #(
  parameter int COL_W = 9,
  parameter int ROW_W = 12
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mem_clk,
  // Control settings
  input wire logic controller_enable,
  input wire logic boot_select,
  input wire logic [2:0] access_mode_select,
  input wire logic row_to_column_delay_sel,
  input wire logic [1:0] cas_latency,
  input wire logic refresh_enable,
  input wire logic low_power_enable,
  // Service requests
  input wire logic refresh_req,
  input wire logic low_power_req,
  input wire logic suspend_timeout,
  // Bus master
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [COL_W+ROW_W+3:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic req_burst_n,
  input wire logic req_load_multiple,
  output logic req_busy,
  output logic ack,
  output logic [31:0] rdata,
  // Memory pins
  output logic mem_cke,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [1:0] mem_ba,
  output logic [11:0] mem_a,
  output logic [31:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [31:0] mem_dq_in
);
  import sdram_engine_pkg::*;

  localparam int ADDR_W = COL_W + ROW_W + 4;

  function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] addr);
    row_of = addr[ADDR_W-1:COL_W+4];
  endfunction

  function automatic logic [1:0] bank_of(input logic [ADDR_W-1:0] addr);
    bank_of = addr[COL_W+3:COL_W+2];
  endfunction

  function automatic logic [11:0] col_of(input logic [ADDR_W-1:0] addr);
    col_of = 12'h000;
    col_of[COL_W-1:0] = addr[COL_W+1:2];
  endfunction

  // ****************************************
  // System clock side
  // ****************************************
  logic busy, next_busy;
  logic next_ack;
  logic [31:0] next_rdata;
  logic req_tog, next_req_tog;
  logic ref_tog, next_ref_tog;
  logic [ADDR_W-1:0] h_addr, next_h_addr;
  logic [31:0] h_wdata, next_h_wdata;
  logic h_write, next_h_write;
  logic h_burst_n, next_h_burst_n;
  logic h_ldm, next_h_ldm;
  logic boot_pending, next_boot_pending;
  logic boot_latched, next_boot_latched;
  logic enabled, next_enabled;
  logic ack_seen, next_ack_seen;
  logic ack_arrived;
  logic [31:0] rdata_m;
  logic ack_tog_m;

  sync_if #(.W(2)) back_if ();
  bit_sync back_sync (
    .clk(ref_clk),
    .port(back_if.core)
  );
  assign back_if.async_in = {ack_tog_m, boot_select};
  assign ack_arrived = back_if.sync_out[1] ^ ack_seen;

  always_comb begin
    next_busy = busy;
    next_ack = 1'b0;
    next_rdata = rdata;
    next_req_tog = req_tog;
    next_ref_tog = ref_tog ^ refresh_req;
    next_h_addr = h_addr;
    next_h_wdata = h_wdata;
    next_h_write = h_write;
    next_h_burst_n = h_burst_n;
    next_h_ldm = h_ldm;
    next_ack_seen = back_if.sync_out[1];
    // Strap is caught one cycle after release, never by the reset itself
    next_boot_pending = 1'b0;
    next_boot_latched = boot_pending ? back_if.sync_out[0] : boot_latched;
    next_enabled = controller_enable | next_boot_latched;
    if (ack_arrived) begin
      next_busy = 1'b0;
      next_ack = 1'b1;
      next_rdata = rdata_m;
    end
    // Busy already low in the ack cycle, so the next request is taken there
    if (req_valid && !busy) begin
      next_busy = 1'b1;
      next_req_tog = ~req_tog;
      next_h_addr = req_addr;
      next_h_wdata = req_wdata;
      next_h_write = req_write;
      next_h_burst_n = req_burst_n;
      next_h_ldm = req_load_multiple;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      req_tog <= 1'b0;
      ref_tog <= 1'b0;
      h_addr <= '0;
      h_wdata <= 32'h0000_0000;
      h_write <= 1'b0;
      h_burst_n <= 1'b1;
      h_ldm <= 1'b0;
      ack_seen <= 1'b0;
      boot_pending <= 1'b1;
      boot_latched <= 1'b0;
      enabled <= 1'b0;
    end else begin
      busy <= next_busy;
      ack <= next_ack;
      rdata <= next_rdata;
      req_tog <= next_req_tog;
      ref_tog <= next_ref_tog;
      h_addr <= next_h_addr;
      h_wdata <= next_h_wdata;
      h_write <= next_h_write;
      h_burst_n <= next_h_burst_n;
      h_ldm <= next_h_ldm;
      ack_seen <= next_ack_seen;
      boot_pending <= next_boot_pending;
      boot_latched <= next_boot_latched;
      enabled <= next_enabled;
    end
  end

  assign req_busy = busy;

  // ****************************************
  // Memory clock side
  // ****************************************
  // Settings and levels are quasi-static; the held request is stable while busy
  sync_if #(.W(14)) fwd_if ();
  bit_sync fwd_sync (
    .clk(mem_clk),
    .port(fwd_if.core)
  );
  assign fwd_if.async_in = {rst, enabled, req_tog, ref_tog, access_mode_select, row_to_column_delay_sel,
                            cas_latency, refresh_enable, low_power_enable, low_power_req, suspend_timeout};

  logic rst_m, en_m, req_tog_m, ref_tog_m, rcd_m, refen_m, lpen_m, lp_m;
  logic [2:0] mode_m;
  logic [1:0] cl_m;
  assign {rst_m, en_m, req_tog_m, ref_tog_m, mode_m, rcd_m, cl_m, refen_m, lpen_m} = fwd_if.sync_out[13:2];
  assign lp_m = |fwd_if.sync_out[1:0];

  state_t state, next_state;
  state_t pre_after, next_pre_after;
  cmd_t cmd, next_cmd;
  logic cke, next_cke;
  logic [1:0] ba, next_ba;
  logic [11:0] a, next_a;
  logic [31:0] dq_out, next_dq_out;
  logic dq_oe, next_dq_oe;
  logic [31:0] next_rdata_m;
  logic next_ack_tog_m;
  logic [3:0] cnt, next_cnt;
  logic [2:0] burst_cnt, next_burst_cnt;
  logic req_pend, next_req_pend;
  logic ref_pend, next_ref_pend;
  logic svc_timer, next_svc_timer;
  logic req_seen, ref_seen;
  logic [3:0] open_valid, next_open_valid;
  logic [ROW_W-1:0] open_row [4];
  logic [ROW_W-1:0] next_open_row [4];
  logic [31:0] dq_s1, dq_s2;
  logic [1:0] bank;
  logic hit;
  logic [3:0] rcd_wait;

  assign bank = bank_of(h_addr);
  assign hit = open_valid[bank] && (open_row[bank] == row_of(h_addr));
  assign rcd_wait = (rcd_m ? `RCD_LONG : `RCD_SHORT) - 4'h2;

  always_comb begin
    next_state = state;
    next_pre_after = pre_after;
    next_cmd = `CMD_NOP;
    next_cke = 1'b1;
    next_ba = ba;
    next_a = a;
    next_dq_out = dq_out;
    next_dq_oe = 1'b0;
    next_rdata_m = rdata_m;
    next_ack_tog_m = ack_tog_m;
    next_cnt = cnt + 4'h1;
    next_burst_cnt = burst_cnt;
    next_req_pend = req_pend | (req_tog_m ^ req_seen);
    next_ref_pend = ref_pend | (ref_tog_m ^ ref_seen);
    next_svc_timer = svc_timer;
    next_open_valid = open_valid;
    next_open_row = open_row;
    unique case (state)
      S_IDLE: begin
        if (!en_m) begin
          // Disabled: pins deselected, requests answered without memory traffic
          next_cmd = `CMD_DESELECT;
          next_ref_pend = 1'b0;
          if (req_pend) begin
            next_ack_tog_m = ~ack_tog_m;
            next_req_pend = 1'b0;
          end
        end else if (ref_pend && refen_m) begin
          next_svc_timer = 1'b1;
          next_state = S_REF;
        end else if (lp_m && lpen_m) begin
          next_cmd = `CMD_DESELECT;
          next_cke = 1'b0;
          next_state = S_PDN;
        end else if (req_pend) begin
          next_svc_timer = 1'b0;
          unique case (mode_m)
            `MODE_NORMAL: begin
              if (hit) begin
                next_state = S_RCD;
                next_cnt = rcd_wait;
              end else if (open_valid[bank]) begin
                next_pre_after = S_ACT;
                next_state = S_PRE;
              end else begin
                next_state = S_ACT;
              end
            end
            `MODE_PRECHARGE: begin
              next_pre_after = S_IDLE;
              next_state = S_PRE;
            end
            `MODE_REFRESH: next_state = S_REF;
            `MODE_MODE_SET: next_state = S_MRS;
            default: begin
              next_ack_tog_m = ~ack_tog_m;
              next_req_pend = 1'b0;
            end
          endcase
        end
        // Open banks are closed before any refresh
        if (next_state == S_REF && |open_valid) begin
          next_pre_after = S_REF;
          next_state = S_PRE;
        end
        // Commands are registered on entry to the state that owns them
        unique case (next_state)
          S_PRE: begin
            next_cmd = `CMD_PRECHARGE;
            next_ba = bank;
            next_a = 12'h000;
            if (next_pre_after == S_IDLE) begin
              next_a[`A10_BIT] = h_addr[COL_W+4+`A10_BIT];
            end
            if (next_pre_after == S_REF) begin
              next_a[`A10_BIT] = 1'b1;
            end
            if (next_a[`A10_BIT]) begin
              next_open_valid = 4'h0;
            end else begin
              next_open_valid[bank] = 1'b0;
            end
          end
          S_ACT: begin
            next_cmd = `CMD_ACTIVATE;
            next_ba = bank;
            next_a = 12'(row_of(h_addr));
            next_open_valid[bank] = 1'b1;
            next_open_row[bank] = row_of(h_addr);
          end
          S_REF: next_cmd = `CMD_REFRESH;
          S_MRS: begin
            next_cmd = `CMD_MODE_SET;
            next_ba = bank;
            next_a = 12'(row_of(h_addr));
            next_a[`A11_BIT] = 1'b0;
            next_a[`A10_BIT] = 1'b0;
          end
          default: ;
        endcase
      end
      S_PRE: begin
        if (pre_after == S_ACT) begin
          next_cmd = `CMD_ACTIVATE;
          next_ba = bank;
          next_a = 12'(row_of(h_addr));
          next_open_valid[bank] = 1'b1;
          next_open_row[bank] = row_of(h_addr);
          next_state = S_ACT;
        end else if (pre_after == S_REF) begin
          next_cmd = `CMD_REFRESH;
          next_state = S_REF;
        end else begin
          next_ack_tog_m = ~ack_tog_m;
          next_req_pend = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_ACT: begin
        next_cnt = 4'h0;
        next_state = S_RCD;
      end
      S_RCD: begin
        if (cnt >= rcd_wait) begin
          next_ba = bank;
          next_a = col_of(h_addr);
          next_burst_cnt = (h_burst_n || burst_cnt == `MAX_BURST_LAST) ? 3'h0 : burst_cnt + 3'h1;
          if (h_write) begin
            next_cmd = `CMD_WRITE;
            next_dq_out = h_wdata;
            next_dq_oe = 1'b1;
            next_state = S_WR;
          end else begin
            next_cmd = `CMD_READ;
            next_state = S_RD;
          end
        end
      end
      S_RD: begin
        next_cnt = 4'h0;
        next_state = S_CLW;
        // Count back at zero: last word or the eighth, stop the memory's own burst
        if (burst_cnt == 3'h0 && !h_ldm) begin
          next_cmd = `CMD_BURST_STOP;
          next_ba = bank;
          next_state = S_STOP;
        end
      end
      S_STOP: begin
        next_cnt = 4'h1;
        next_state = S_CLW;
      end
      S_CLW: begin
        // Capture accounts for the two input synchroniser stages
        if (cnt == {2'b00, cl_m} + 4'h1) begin
          next_rdata_m = dq_s2;
          next_ack_tog_m = ~ack_tog_m;
          next_req_pend = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_WR: begin
        next_ack_tog_m = ~ack_tog_m;
        next_req_pend = 1'b0;
        next_state = S_IDLE;
      end
      S_REF: begin
        if (svc_timer) begin
          // A refresh request landing in this cycle is kept
          next_ref_pend = ref_tog_m ^ ref_seen;
        end else begin
          next_ack_tog_m = ~ack_tog_m;
          next_req_pend = 1'b0;
        end
        next_state = S_IDLE;
      end
      S_MRS: begin
        next_ack_tog_m = ~ack_tog_m;
        next_req_pend = 1'b0;
        next_state = S_IDLE;
      end
      S_PDN: begin
        next_cmd = `CMD_DESELECT;
        next_cke = 1'b0;
        if (!(lp_m && lpen_m)) begin
          next_cke = 1'b1;
          next_state = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mem_clk) begin
    dq_s1 <= mem_dq_in;
    dq_s2 <= dq_s1;
    if (rst_m) begin
      state <= S_IDLE;
      pre_after <= S_IDLE;
      cmd <= `CMD_DESELECT;
      cke <= 1'b1;
      ba <= 2'h0;
      a <= 12'h000;
      dq_out <= 32'h0000_0000;
      dq_oe <= 1'b0;
      rdata_m <= 32'h0000_0000;
      ack_tog_m <= 1'b0;
      cnt <= 4'h0;
      burst_cnt <= 3'h0;
      req_pend <= 1'b0;
      ref_pend <= 1'b0;
      svc_timer <= 1'b0;
      req_seen <= 1'b0;
      ref_seen <= 1'b0;
      open_valid <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        open_row[i] <= '0;
      end
    end else begin
      state <= next_state;
      pre_after <= next_pre_after;
      cmd <= next_cmd;
      cke <= next_cke;
      ba <= next_ba;
      a <= next_a;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      rdata_m <= next_rdata_m;
      ack_tog_m <= next_ack_tog_m;
      cnt <= next_cnt;
      burst_cnt <= next_burst_cnt;
      req_pend <= next_req_pend;
      ref_pend <= next_ref_pend;
      svc_timer <= next_svc_timer;
      req_seen <= req_tog_m;
      ref_seen <= ref_tog_m;
      open_valid <= next_open_valid;
      open_row <= next_open_row;
    end
  end

  assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = cmd;
  assign mem_cke = cke;
  assign mem_ba = ba;
  assign mem_a = a;
  assign mem_dq_out = dq_out;
  assign mem_dq_oe = dq_oe;
endmodule // sdram_engine

/* rtl/sdram_engine_consts.svh */
// Constants for the synchronous DRAM command and read/write engine
`ifndef SDRAM_ENGINE_CONSTS_SVH
`define SDRAM_ENGINE_CONSTS_SVH

// ****************************************
// Command words {cs_n, ras_n, cas_n, we_n}
// ****************************************
`define CMD_DESELECT 4'hf
`define CMD_NOP 4'h7
`define CMD_ACTIVATE 4'h3
`define CMD_READ 4'h5
`define CMD_WRITE 4'h4
`define CMD_BURST_STOP 4'h6
`define CMD_PRECHARGE 4'h2
`define CMD_REFRESH 4'h1
`define CMD_MODE_SET 4'h0

// ****************************************
// Access mode field codes
// ****************************************
`define MODE_NORMAL 3'h0
`define MODE_PRECHARGE 3'h1
`define MODE_REFRESH 3'h2
`define MODE_MODE_SET 3'h3

// ****************************************
// Address pin positions and timing
// ****************************************
`define A10_BIT 10
`define A11_BIT 11
`define RCD_SHORT 4'h2
`define RCD_LONG 4'h3
`define MAX_BURST_LAST 3'h7

`endif

/* rtl/sdram_engine_pkg.sv */
// Types shared by the synchronous DRAM engine
package sdram_engine_pkg;
  typedef enum logic [10:0] {
    S_IDLE = 11'h001,
    S_PRE = 11'h002,
    S_ACT = 11'h004,
    S_RCD = 11'h008,
    S_RD = 11'h010,
    S_STOP = 11'h020,
    S_CLW = 11'h040,
    S_WR = 11'h080,
    S_REF = 11'h100,
    S_MRS = 11'h200,
    S_PDN = 11'h400
  } state_t;
  typedef logic [3:0] cmd_t;
endpackage

/* rtl/sync_if.sv */
// Bundle between the engine and its two-stage synchroniser
interface sync_if #(parameter int W = 1);
  logic [W-1:0] async_in;
  logic [W-1:0] sync_out;
  modport core (input async_in, output sync_out);
  modport user (output async_in, input sync_out);
endinterface

/* rtl/bit_sync.sv */
// Two flip-flop synchroniser for levels and toggles
module bit_sync (
  // Destination clock
  input wire logic clk,
  // Signals to cross
  sync_if.core port
);
  logic [$bits(port.async_in)-1:0] stage1;
  logic [$bits(port.async_in)-1:0] stage2;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    stage1 <= port.async_in;
    stage2 <= stage1;
  end

  assign port.sync_out = stage2;
endmodule // bit_sync

/* tb/sdram_engine_checker.sv */
// Port-level assertions for the engine
`include "sdram_engine_consts.svh"

module sdram_engine_checker #(
  parameter int COL_W = 9,
  parameter int ROW_W = 12
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mem_clk,
  // Settings and bus master
  input wire logic row_to_column_delay_sel,
  input wire logic req_valid,
  input wire logic req_busy,
  input wire logic ack,
  // Memory pins
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [11:0] mem_a,
  input wire logic mem_dq_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cmd;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};

  // ****************************************
  // Command steps
  // ****************************************
  sequence act_s;
    cmd == `CMD_ACTIVATE;
  endsequence
  sequence nop_s;
    cmd == `CMD_NOP;
  endsequence
  sequence rw_s;
    cmd == `CMD_READ || cmd == `CMD_WRITE;
  endsequence

  rst_idle_a: assert property (@(posedge ref_clk) rst |=> !req_busy && !ack)
    else $error("busy or ack during reset");
  ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst) ack |-> !req_busy ##1 !ack)
    else $error("ack not a free one-cycle pulse");
  take_req_a: assert property (@(posedge ref_clk) disable iff (rst) req_valid && !req_busy |=> req_busy || ack)
    else $error("request not taken");
  wr_data_a: assert property (@(posedge mem_clk) disable iff (rst) mem_dq_oe == (cmd == `CMD_WRITE))
    else $error("write data not with write command");
  rw_a10_a: assert property (@(posedge mem_clk) disable iff (rst) rw_s |-> !mem_a[10])
    else $error("A10 high on read or write");
  stop_pipe_a: assert property (@(posedge mem_clk) disable iff (rst) cmd == `CMD_BURST_STOP |-> $past(cmd) == `CMD_READ)
    else $error("burst stop not after read");
  rcd_short_a: assert property (@(posedge mem_clk) disable iff (rst) act_s and !row_to_column_delay_sel |=> nop_s ##1 rw_s)
    else $error("row to column delay not 2");
  rcd_long_a: assert property (@(posedge mem_clk) disable iff (rst) act_s and row_to_column_delay_sel |=> nop_s [*2] ##1 rw_s)
    else $error("row to column delay not 3");
  mode_set_a: assert property (@(posedge mem_clk) disable iff (rst) cmd == `CMD_MODE_SET |-> mem_a[11:10] == 2'h0)
    else $error("mode set with A11 or A10 high");
  cke_low_a: assert property (@(posedge mem_clk) disable iff (rst) !mem_cke || $rose(mem_cke) |-> mem_cs_n)
    else $error("chip select low around power down");
endmodule // sdram_engine_checker

bind sdram_engine sdram_engine_checker #(.COL_W(COL_W), .ROW_W(ROW_W)) i_chk (.ref_clk, .rst, .mem_clk,
  .row_to_column_delay_sel, .req_valid, .req_busy, .ack, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n,
  .mem_we_n, .mem_a, .mem_dq_oe);

/* tb/sdram_mem_model.sv */
// Behavioural memory on the far side of the engine
`include "sdram_engine_consts.svh"

module sdram_mem_model (
  // Clock and command pins
  input wire logic mem_clk,
  input wire logic [3:0] cmd,
  input wire logic [1:0] ba,
  input wire logic [11:0] a,
  // Data
  input wire logic [31:0] dq_out,
  input wire logic dq_oe,
  input wire logic [1:0] cl,
  output logic [31:0] dq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] store [0:2047];
  logic [3:0] rd_v = 4'h0;
  logic [3:0][31:0] rd_d;
  logic [31:0] last = 32'h0;
  logic drive;
  assign drive = rd_v[cl - 2'h1];
  // Released bus toggles so a stale word never looks valid
  assign dq = drive ? rd_d[cl - 2'h1] : ~last;
  always @(posedge mem_clk) begin
    if (cmd == `CMD_WRITE && dq_oe) store[{ba, a[8:0]}] <= dq_out;
    rd_v <= {rd_v[2:0], cmd == `CMD_READ};
    rd_d <= {rd_d[2:0], store[{ba, a[8:0]}]};
    last <= dq;
  end
endmodule // sdram_mem_model

/* tb/sdram_engine_test.sv */
// Self-checking bench for the engine
`include "sdram_engine_consts.svh"

module sdram_engine_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, mem_clk = 0, rst = 1, controller_enable = 0, boot_select = 0;
  logic row_to_column_delay_sel = 0, refresh_enable = 0, low_power_enable = 0, refresh_req = 0;
  logic low_power_req = 0, suspend_timeout = 0, req_valid = 0, req_write = 0, req_burst_n = 1;
  logic req_load_multiple = 0, req_busy, ack, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_dq_oe;
  logic [2:0] access_mode_select = 3'h0;
  logic [1:0] cas_latency = 2'h2, mem_ba;
  logic [11:0] mem_a;
  logic [24:0] req_addr = 25'h0;
  logic [31:0] req_wdata = 32'h0, rdata, mem_dq_out, mem_dq_in;
  logic [3:0] mc [3] = '{`CMD_PRECHARGE, `CMD_REFRESH, `CMD_MODE_SET};
  int fails = 0, total_checks = 0, cnt [16], base [16];

  sdram_engine i_dut (.ref_clk, .rst, .mem_clk, .controller_enable, .boot_select, .access_mode_select,
    .row_to_column_delay_sel, .cas_latency, .refresh_enable, .low_power_enable, .refresh_req, .low_power_req,
    .suspend_timeout, .req_valid, .req_write, .req_addr, .req_wdata, .req_burst_n, .req_load_multiple,
    .req_busy, .ack, .rdata, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_ba, .mem_a,
    .mem_dq_out, .mem_dq_oe, .mem_dq_in);
  sdram_mem_model i_mem (.mem_clk, .cmd({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}), .ba(mem_ba),
    .a(mem_a), .dq_out(mem_dq_out), .dq_oe(mem_dq_oe), .cl(cas_latency), .dq(mem_dq_in));

  always #4 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #3 mem_clk = ~mem_clk;
  end
  always @(posedge mem_clk) if (!rst && mem_cke === 1'b1) cnt[{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}]++;

  // ****************************************
  // Access and compare tasks
  // ****************************************
  function automatic logic [24:0] ad(input int r, b, c);
    return {r[11:0], b[1:0], c[8:0], 2'h0};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_d(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input logic [3:0] c, input int e);
    total_checks++;
    if (cnt[c] - base[c] != e) begin
      fails++;
      $display("[FAIL] %0t command %h count %0d expected %0d", $time, c, cnt[c] - base[c], e);
    end
  endtask
  task automatic acc(input logic w, input logic [24:0] a, input logic [31:0] d, input logic bn = 1, lm = 0);
    int n;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_burst_n = bn;
    req_load_multiple = lm;
    req_valid = 1;
    idle(1);
    req_valid = 0;
    for (n = 0; ack !== 1'b1 && n < 200; n++) idle(1);
    if (n == 200) chk_d(32'h0, 32'h1);
  endtask
  task automatic results;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #60us;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    results;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    idle(16);
    chk_d(32'({mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, req_busy}), 32'h3e);
    rst = 0;
    idle(10);
    base = cnt;
    acc(0, ad(1, 0, 0), 32'h0);
    chk_n(`CMD_ACTIVATE, 0);
    rst = 1;
    boot_select = 1;
    idle(16);
    rst = 0;
    idle(10);
    base = cnt;
    acc(1, ad(1, 0, 4), 32'h1234abcd);
    chk_n(`CMD_WRITE, 1);
    controller_enable = 1;
    for (int i = 0; i < 4; i++) begin
      row_to_column_delay_sel = i[0];
      cas_latency = 2'(2 + i / 2);
      idle(8);
      base = cnt;
      acc(1, ad(2, i, 8), {28'ha5a5a5a, i[3:0]});
      chk_n(`CMD_ACTIVATE, 1);
      chk_n(`CMD_WRITE, 1);
      base = cnt;
      acc(0, ad(2, i, 8), 32'h0);
      chk_n(`CMD_ACTIVATE, 0);
      chk_n(`CMD_BURST_STOP, 1);
      chk_d(rdata, {28'ha5a5a5a, i[3:0]});
    end
    base = cnt;
    acc(0, ad(5, 1, 8), 32'h0);
    chk_n(`CMD_PRECHARGE, 1);
    chk_n(`CMD_ACTIVATE, 1);
    chk_d(rdata, 32'ha5a5a5a1);
    base = cnt;
    for (int k = 0; k < 8; k++) acc(1, ad(5, 1, 16 + k), {24'hc0ffee, k[7:0]}, k == 7);
    chk_n(`CMD_WRITE, 8);
    chk_n(`CMD_BURST_STOP, 0);
    base = cnt;
    for (int k = 0; k < 8; k++) begin
      acc(0, ad(5, 1, 16 + k), 32'h0, k == 7);
      chk_d(rdata, {24'hc0ffee, k[7:0]});
    end
    chk_n(`CMD_READ, 8);
    chk_n(`CMD_BURST_STOP, 1);
    base = cnt;
    acc(0, ad(5, 1, 17), 32'h0, 1, 1);
    chk_n(`CMD_BURST_STOP, 0);
    chk_d(rdata, 32'hc0ffee01);
    for (int m = 1; m < 4; m++) begin
      access_mode_select = 3'(m);
      idle(8);
      base = cnt;
      acc(1, ad(12'h423, 2, 0), 32'h0);
      chk_n(mc[m - 1], 1);
      chk_n(`CMD_ACTIVATE, 0);
    end
    access_mode_select = 3'h0;
    idle(8);
    base = cnt;
    acc(0, ad(5, 1, 17), 32'h0);
    chk_n(`CMD_ACTIVATE, 1);
    chk_d(rdata, 32'hc0ffee01);
    for (int e = 0; e < 2; e++) begin
      refresh_enable = e[0];
      idle(8);
      base = cnt;
      refresh_req = 1;
      idle(1);
      refresh_req = 0;
      idle(40);
      chk_n(`CMD_REFRESH, e);
    end
    low_power_enable = 1;
    for (int s = 0; s < 2; s++) begin
      {low_power_req, suspend_timeout} = s ? 2'b01 : 2'b10;
      idle(20);
      chk_d(32'(mem_cke), 32'h0);
      {low_power_req, suspend_timeout} = 2'b00;
      idle(20);
      chk_d(32'(mem_cke), 32'h1);
    end
    acc(0, ad(2, 3, 8), 32'h0);
    chk_d(rdata, 32'ha5a5a5a3);
    results;
  end
endmodule // sdram_engine_test
